/* File: verification/can_tx_remote_answer_arbitration_bench.sv */
// Self-checking bench for transmit-candidate selection
`timescale 1ns/100ps
module can_tx_remote_answer_arbitration_bench;
  import ctas_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
  logic rx_sof, ifs_end, rx_rtr_done, cand_valid, cand_ready, mreq, mack;
  logic tx_done;
  logic [IDX_W-1:0] tx_idx;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [ID_W-1:0] rx_id;
  logic [IDX_W-1:0] cand_idx;
  logic e;
  int bad_count, checked, n0, last;
  logic [3:0] code[16];
  logic [10:0] id[16];

  ctas_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_sof(rx_sof), .ifs_end(ifs_end), .rx_rtr_done(rx_rtr_done),
    .rx_id(rx_id), .tx_done(tx_done), .tx_done_idx(tx_idx), .cand_valid(cand_valid),
    .cand_ready(cand_ready), .cand_idx(cand_idx), .mode_disable_req(mreq),
    .mode_disable_ack(mack));
  ctas_partner i_partner (.pclk(pclk), .stall(stall), .rx_sof(rx_sof), .ifs_end(ifs_end),
    .rx_rtr_done(rx_rtr_done), .rx_id(rx_id), .cand_valid(cand_valid),
    .cand_ready(cand_ready), .cand_idx(cand_idx));

  always #25 pclk = ~pclk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h", $time, m, got);
      bad_count++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
  endtask : apb
  // Write a buffer word and mirror it in the model
  task automatic wbuf(input int i, input logic [3:0] c, input logic [10:0] v);
    code[i] = c;
    id[i] = v;
    apb(1'b1, OFF_BUF_BASE + 12'(4 * i), {4'h0, c, 13'h0, v});
  endtask : wbuf
  function automatic int winner();
    int b;
    b = -1;
    for (int i = 0; i <= last; i++)
      if (code[i] == CODE_TX_DATA && (b < 0 || id[i] < id[b]))
        b = i;
    return b;
  endfunction : winner
  task automatic pops_grew(input int k, input string m);
    chk(i_partner.pops.size(), n0 + k, m);
  endtask : pops_grew

  initial begin
    #(50 * 60000);
    bad_count++;
    finish_test();
  end
  initial begin
    {pclk, psel, penable, pwrite, stall, mreq, presetn, tx_done} = '0;
    tx_idx = '0;
    paddr = '0;
    pwdata = '0;
    for (int i = 0; i < 16; i++) begin
      code[i] = 4'h0;
      id[i] = 11'h0;
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(52449));
    apb(1'b0, OFF_MODULE_CONFIG, 32'h0);
    chk(r, 32'hd000000f, "config reset");
    mreq <= 1'b1;
    @(negedge pclk) chk(mack, 1'b1, "ack while disabled");
    last = 7;
    apb(1'b1, OFF_MODULE_CONFIG, 32'h7);
    @(negedge pclk) chk(mack, 1'b0, "ack while enabled");
    mreq <= 1'b0;
    $display("test reset and config done");
    // Buffers above the last index carry the lowest ids and must lose
    for (int i = 0; i < 10; i++)
      wbuf(i, CODE_TX_DATA, (i > 7) ? 11'h0 : 11'($urandom % 2048));
    repeat (24) @(posedge pclk);
    n0 = i_partner.pops.size();
    i_partner.frame(1'b0, 11'h0, 20);
    pops_grew(1, "candidate by intermission");
    chk(i_partner.pops[$], winner(), "scan winner");
    $display("test scan done");
    wbuf(3, CODE_REMOTE_ANS, 11'h0);
    i_partner.frame(1'b1, 11'h0, 20);
    code[3] = CODE_TX_DATA;
    repeat (24) @(posedge pclk);
    chk(i_partner.pops[$], winner(), "remote answer armed");
    apb(1'b0, OFF_BUF_BASE + 12'hc, 32'h0);
    chk(r[27:24], CODE_TX_DATA, "remote answer code");
    // Last buffer as remote answer, software breaking its own placement rule
    wbuf(7, CODE_REMOTE_ANS, 11'h7ff);
    repeat (24) @(posedge pclk);
    n0 = i_partner.pops.size();
    i_partner.frame(1'b1, 11'h7fe, 20);
    pops_grew(1, "candidate kept");
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({r[8], r[3:0]}, {1'b1, 4'(winner())}, "status after stray request");
    $display("test remote done");
    n0 = i_partner.pops.size();
    wbuf(7, CODE_REMOTE_ANS, 11'h7ff);
    repeat (24) @(posedge pclk);
    pops_grew(1, "rescan on cs write");
    n0 = i_partner.pops.size();
    i_partner.frame(1'b0, 11'h0, 20);
    pops_grew(1, "rescan on new frame");
    stall <= 1'b1;
    repeat (3) @(posedge pclk);
    n0 = i_partner.pops.size();
    repeat (3) i_partner.frame(1'b0, 11'h0, 20);
    chk(cand_valid, 1'b1, "valid held under stall");
    pops_grew(0, "no pop under stall");
    stall <= 1'b0;
    repeat (10) @(posedge pclk);
    pops_grew(3, "two stored plus pending");
    $display("test rescan and stall done");
    // Transmitter reports the winner sent: its buffer retires and a new pick follows
    n0 = i_partner.pops.size();
    tx_idx <= i_partner.pops[$];
    tx_done <= 1'b1;
    code[i_partner.pops[$]] = CODE_TX_INACTIVE;
    @(posedge pclk) tx_done <= 1'b0;
    repeat (24) @(posedge pclk);
    pops_grew(1, "rescan after send");
    chk(i_partner.pops[$], winner(), "next winner after send");
    $display("test send done");
    for (int i = 0; i < 7; i++)
      wbuf(i, CODE_TX_INACTIVE, id[i]);
    repeat (24) @(posedge pclk);
    n0 = i_partner.pops.size();
    i_partner.frame(1'b0, 11'h0, 20);
    pops_grew(0, "idle transmitter");
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(r[8], 1'b0, "no candidate found");
    wbuf(5, CODE_TX_DATA, 11'($urandom % 2048));
    repeat (24) @(posedge pclk);
    chk(i_partner.pops[$], 5, "activation rescans");
    $display("test idle done");
    apb(1'b0, 12'h040, 32'h0);
    chk(e, 1'b1, "unmapped read");
    apb(1'b1, OFF_STATUS, 32'h0);
    chk(e, 1'b1, "status write");
    mreq <= 1'b1;
    @(negedge pclk) chk(mack, 1'b0, "mode entry blocked");
    apb(1'b1, OFF_MODULE_CONFIG, 32'hd0000007);
    @(negedge pclk) chk(mack, 1'b1, "mode entry done");
    $display("test apb and mode done");
    finish_test();
  end
endmodule : can_tx_remote_answer_arbitration_bench

/* File: verification/ctas_partner.sv */
// Far-side model: other nodes' frames on the bus and the transmitter taking candidates
`timescale 1ns/100ps
module ctas_partner (
  // Clock and bench control
  input  wire logic                       pclk,
  input  wire logic                       stall,
  // Frame events
  output      logic                       rx_sof,
  output      logic                       ifs_end,
  output      logic                       rx_rtr_done,
  output      logic [ctas_pkg::ID_W-1:0]  rx_id,
  // Candidate hand-over
  input  wire logic                       cand_valid,
  output      logic                       cand_ready,
  input  wire logic [ctas_pkg::IDX_W-1:0] cand_idx
);
  import ctas_pkg::*;
  logic [IDX_W-1:0] pops[$];
  initial begin
    rx_sof = 1'b0;
    ifs_end = 1'b0;
    rx_rtr_done = 1'b0;
    rx_id = 11'h7ff;
    cand_ready = 1'b1;
  end
  // Slow transmitter: ready follows the bench's stall request one cycle late
  always @(posedge pclk) begin
    cand_ready <= !stall;
    if (cand_valid && cand_ready)
      pops.push_back(cand_idx);
  end
  // ----------------------------------------
  // One frame seen on the bus, optionally a remote request
  // ----------------------------------------
  task automatic frame(input logic rtr, input logic [ID_W-1:0] id, input int len);
    @(posedge pclk) rx_sof <= 1'b1;
    @(posedge pclk) rx_sof <= 1'b0;
    repeat (len) @(posedge pclk);
    if (rtr) begin
      @(posedge pclk) rx_rtr_done <= 1'b1;
      rx_id <= id;
      @(posedge pclk) rx_rtr_done <= 1'b0;
      // Released id lines show no stale value
      rx_id <= ~id;
    end
    @(posedge pclk) ifs_end <= 1'b1;
    @(posedge pclk) ifs_end <= 1'b0;
  endtask : frame
endmodule : ctas_partner

/* File: verilog/ctas_buf2.sv */
// Two-entry valid/ready buffer for selected candidates
`timescale 1ns/100ps
module ctas_buf2 #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Fill side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [2];
  logic         wp_reg;
  logic         rp_reg;
  logic [1:0]   cnt_reg;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_data;
        wp_reg          <= !wp_reg;
      end
      if (pop) begin
        rp_reg <= !rp_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : ctas_buf2

/* File: verilog/ctas_pkg.sv */
// Constants shared by the transmit-candidate arbitration block
package ctas_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_BUF = 16;
  localparam int IDX_W   = 4;
  localparam int ID_W    = 11;
  localparam int CODE_W  = 4;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_MODULE_CONFIG = 12'h000;
  localparam logic [11:0] OFF_STATUS        = 12'h004;
  localparam logic [11:0] OFF_BUF_BASE      = 12'h080;
  localparam logic [11:0] OFF_BUF_LAST      = 12'h0bc;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_LAST_IDX = 0;
  localparam int POS_HALT     = 28;
  localparam int POS_FRZ_EN   = 30;
  localparam int POS_MODULE_DISABLE_BIT     = 31;
  localparam int POS_ID       = 0;
  localparam int POS_CODE     = 24;
  localparam int POS_CAND_IDX = 0;
  localparam int POS_CAND_VAL = 8;
  localparam int POS_SCANNING = 9;
  localparam int POS_DIS_ACK  = 10;
  localparam int POS_TX_IDLE  = 11;
  // ----------------------------------------
  // Buffer codes and reset values
  // ----------------------------------------
  localparam logic [CODE_W-1:0] CODE_RX_INACTIVE = 4'h0;
  localparam logic [CODE_W-1:0] CODE_TX_INACTIVE = 4'h8;
  localparam logic [CODE_W-1:0] CODE_REMOTE_ANS  = 4'ha;
  localparam logic [CODE_W-1:0] CODE_TX_DATA     = 4'hc;
  localparam logic [IDX_W-1:0]  RST_LAST_IDX     = 4'hf;
  localparam logic              RST_MODULE_DISABLE_BIT         = 1'b1;
  localparam logic              RST_FRZ_EN       = 1'b1;
  localparam logic              RST_HALT         = 1'b1;
  // Worst scan length: every buffer plus the closing cycle
  localparam int SCAN_MAX_CYC = NUM_BUF + 1;
endpackage : ctas_pkg

/* File: verilog/ctas_top.sv */
// Transmit-candidate selection, remote answers and mode-entry handshake
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module ctas_top
  import ctas_pkg::*;
(
  // APB slave
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output      logic [31:0]              prdata,
  output      logic                     pready,
  output      logic                     pslverr,
  // Frame events from the protocol engine
  input  wire logic                     rx_sof,
  input  wire logic                     ifs_end,
  input  wire logic                     rx_rtr_done,
  input  wire logic [ctas_pkg::ID_W-1:0] rx_id,
  input  wire logic                     tx_done,
  input  wire logic [ctas_pkg::IDX_W-1:0] tx_done_idx,
  // Candidate to the transmitter
  output      logic                     cand_valid,
  input  wire logic                     cand_ready,
  output      logic [ctas_pkg::IDX_W-1:0] cand_idx,
  // Chip mode controller handshake
  input  wire logic                     mode_disable_req,
  output      logic                     mode_disable_ack
);
  import ctas_pkg::*;

  // ----------------------------------------
  // Configuration and buffer storage
  // ----------------------------------------
  logic [IDX_W-1:0]  last_buffer_index_reg;
  logic              module_disable_bit_reg;
  logic              freeze_enable_bit_reg;
  logic              halt_reg;
  logic [CODE_W-1:0] code_mem [NUM_BUF];
  logic [ID_W-1:0]   id_mem   [NUM_BUF];
  logic [31:0]       prdata_reg;
  logic              perr_reg;
  logic              after_ifs_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire              setup     = psel && !penable;
  wire              wr_en     = psel && penable && pwrite;
  wire              hit_cfg   = (paddr == OFF_MODULE_CONFIG);
  wire              hit_stat  = (paddr == OFF_STATUS);
  wire              hit_buf   = (paddr >= OFF_BUF_BASE) && (paddr <= OFF_BUF_LAST)
                                && (paddr[1:0] == 2'h0);
  wire              mapped    = hit_cfg || hit_stat || hit_buf;
  wire [11:0]       buf_off   = paddr - OFF_BUF_BASE;
  wire [IDX_W-1:0]  buf_sel   = buf_off[IDX_W+1:2];
  wire              cs_wr     = wr_en && hit_buf;
  wire              cfg_wr    = wr_en && hit_cfg;
  wire [CODE_W-1:0] wr_code   = pwdata[POS_CODE+:CODE_W];
  wire              enabled   = !module_disable_bit_reg && !halt_reg;

  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = perr_reg && psel && penable;

  // ----------------------------------------
  // Remote request matching
  // ----------------------------------------
  logic [NUM_BUF-1:0] rmatch;
  genvar g;
  generate
    for (g = 0; g < NUM_BUF; g++) begin : g_match
      assign rmatch[g] = (code_mem[g] == CODE_REMOTE_ANS) && (id_mem[g] == rx_id)
                         && (g <= int'(last_buffer_index_reg));
      AST_RA_ARM: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_rtr_done && enabled && rmatch[g]) |=> (code_mem[g] == CODE_TX_DATA))
        else $error("remote answer buffer not armed");
    end
  endgenerate
  wire arm_any = rx_rtr_done && enabled && (rmatch != '0);

  // ----------------------------------------
  // Selection scan
  // ----------------------------------------
  logic              scan_active_reg;
  logic [IDX_W-1:0]  scan_idx_reg;
  logic              best_v_reg;
  logic [IDX_W-1:0]  best_idx_reg;
  logic [ID_W-1:0]   best_id_reg;
  logic              cand_found_reg;
  logic [IDX_W-1:0]  cand_idx_reg;
  logic              push_pend_reg;
  logic              tx_idle_reg;
  logic              buf_in_ready;

  // A scan restarts on frame start (also one sent after intermission by another node), on rearming,
  // on a buffer write in the post-intermission gap, on any activation write, and on a reported send.
  wire tx_activate = cs_wr && (wr_code == CODE_TX_DATA);
  wire scan_start  = enabled && (rx_sof
                     || (cs_wr && after_ifs_reg)
                     || (tx_activate && tx_idle_reg)
                     || tx_activate || arm_any || tx_done);
  wire [CODE_W-1:0] cur_code = code_mem[scan_idx_reg];
  wire [ID_W-1:0]   cur_id   = id_mem[scan_idx_reg];
  // Lower identifier wins arbitration on the bus, so it is the better pick
  wire cur_better = (cur_code == CODE_TX_DATA) && (!best_v_reg || cur_id < best_id_reg);
  wire scan_last  = scan_active_reg && (scan_idx_reg == last_buffer_index_reg);
  wire found_next = best_v_reg || cur_better;
  wire [IDX_W-1:0] win_next = cur_better ? scan_idx_reg : best_idx_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_active_reg <= 1'b0;
      scan_idx_reg    <= '0;
      best_v_reg      <= 1'b0;
      best_idx_reg    <= '0;
      best_id_reg     <= '0;
    end else if (scan_start) begin
      scan_active_reg <= 1'b1;
      scan_idx_reg    <= '0;
      best_v_reg      <= 1'b0;
    end else if (scan_active_reg) begin
      scan_active_reg <= !scan_last;
      scan_idx_reg    <= scan_idx_reg + 4'h1;
      if (cur_better) begin
        best_v_reg   <= 1'b1;
        best_idx_reg <= scan_idx_reg;
        best_id_reg  <= cur_id;
      end
    end
  end

  // Candidate holds across remote requests; only a finished scan replaces it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cand_found_reg <= 1'b0;
      cand_idx_reg   <= '0;
      push_pend_reg  <= 1'b0;
      tx_idle_reg    <= 1'b1;
    end else if (scan_last && !scan_start) begin
      cand_found_reg <= found_next;
      cand_idx_reg   <= win_next;
      push_pend_reg  <= found_next;
      tx_idle_reg    <= !found_next;
    end else if (push_pend_reg && buf_in_ready) begin
      push_pend_reg  <= 1'b0;
    end
  end

  // ----------------------------------------
  // Candidate hand-off buffer
  // ----------------------------------------
  ctas_buf2 #(.W(IDX_W)) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push_pend_reg),
    .in_ready  (buf_in_ready),
    .in_data   (cand_idx_reg),
    .out_valid (cand_valid),
    .out_ready (cand_ready),
    .out_data  (cand_idx)
  );

  // ----------------------------------------
  // Registers written by software and hardware
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_buffer_index_reg  <= RST_LAST_IDX;
      module_disable_bit_reg <= RST_MODULE_DISABLE_BIT;
      freeze_enable_bit_reg  <= RST_FRZ_EN;
      halt_reg               <= RST_HALT;
    end else if (cfg_wr) begin
      last_buffer_index_reg  <= pwdata[POS_LAST_IDX+:IDX_W];
      module_disable_bit_reg <= pwdata[POS_MODULE_DISABLE_BIT];
      freeze_enable_bit_reg  <= pwdata[POS_FRZ_EN];
      halt_reg               <= pwdata[POS_HALT];
    end
  end

  // Hardware updates come after the bus write, so they win on a collision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        code_mem[i] <= CODE_RX_INACTIVE;
        id_mem[i]   <= '0;
      end
    end else begin
      if (cs_wr) begin
        code_mem[buf_sel] <= wr_code;
        id_mem[buf_sel]   <= pwdata[POS_ID+:ID_W];
      end
      if (tx_done) begin
        code_mem[tx_done_idx] <= CODE_TX_INACTIVE;
      end
      for (int i = 0; i < NUM_BUF; i++) begin
        if (rx_rtr_done && enabled && rmatch[i]) begin
          code_mem[i] <= CODE_TX_DATA;
        end
      end
    end
  end

  // Window between intermission end and the next frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      after_ifs_reg <= 1'b0;
    end else if (rx_sof) begin
      after_ifs_reg <= 1'b0;
    end else if (ifs_end) begin
      after_ifs_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Mode-entry handshake
  // ----------------------------------------
  // The controller's request is only granted once the module is really off
  assign mode_disable_ack = mode_disable_req && module_disable_bit_reg;

  // ----------------------------------------
  // Read path, answered in the access cycle
  // ----------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_cfg) begin
      rd_word[POS_LAST_IDX+:IDX_W] = last_buffer_index_reg;
      rd_word[POS_MODULE_DISABLE_BIT]            = module_disable_bit_reg;
      rd_word[POS_FRZ_EN]          = freeze_enable_bit_reg;
      rd_word[POS_HALT]            = halt_reg;
    end else if (hit_stat) begin
      rd_word[POS_CAND_IDX+:IDX_W] = cand_idx_reg;
      rd_word[POS_CAND_VAL]        = cand_found_reg;
      rd_word[POS_SCANNING]        = scan_active_reg;
      rd_word[POS_DIS_ACK]         = mode_disable_ack;
      rd_word[POS_TX_IDLE]         = tx_idle_reg;
    end else if (hit_buf) begin
      rd_word[POS_CODE+:CODE_W]    = code_mem[buf_sel];
      rd_word[POS_ID+:ID_W]        = id_mem[buf_sel];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      perr_reg   <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
      perr_reg   <= !mapped || (pwrite && hit_stat);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_scan_begin;
    scan_start;
  endsequence
  sequence s_scan_end;
    scan_last && !scan_start;
  endsequence
  // Idle transmitter with no scan under way, then software activates a buffer
  sequence s_idle_then_activate;
    (tx_idle_reg && !scan_active_reg && !scan_start) ##1
    (tx_activate && enabled && !rx_sof)[*1];
  endsequence

  AST_SCAN_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
    s_scan_begin |=> ##[0:16] !scan_active_reg || scan_start)
    else $error("scan ran past its bound");
  AST_SOF_SCAN: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_sof && enabled) |=> scan_active_reg && (scan_idx_reg == 4'h0))
    else $error("frame start did not start a scan");
  AST_IDX_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    scan_active_reg |-> (scan_idx_reg <= last_buffer_index_reg) || $past(cfg_wr))
    else $error("scan passed the last buffer index");
  AST_KEEP_CAND: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_rtr_done && rmatch == '0 && !(scan_last && !scan_start))
    |=> $stable(cand_found_reg) && $stable(cand_idx_reg))
    else $error("candidate lost on unmatched remote request");
  AST_CS_RESCAN: assert property (@(posedge pclk) disable iff (!presetn)
    (cs_wr && after_ifs_reg && enabled) |=> scan_active_reg && scan_idx_reg == 4'h0)
    else $error("buffer write after intermission did not rescan");
  AST_DIS_ACK: assert property (@(posedge pclk) disable iff (!presetn)
    mode_disable_ack |-> module_disable_bit_reg && mode_disable_req)
    else $error("disable granted while module still enabled");
  AST_IDLE_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    s_idle_then_activate |=> scan_active_reg ##[1:16] (!tx_idle_reg || scan_start))
    else $error("activation while idle did not select a candidate");
  AST_WINNER: assert property (@(posedge pclk) disable iff (!presetn)
    (s_scan_end and found_next) |=> cand_found_reg
    && code_mem[cand_idx_reg] == CODE_TX_DATA || $past(cs_wr || tx_done))
    else $error("chosen candidate is not a pending transmit buffer");
endmodule : ctas_top
